/* File: src/mac_dma_status_pkg.sv */
// Register map, field positions and reset values of the MAC DMA status and interrupt block
package mac_dma_status_pkg;
   // Byte addresses of the registers on the register port
   localparam logic [31:0] TX_QUEUE_PTR_ADDR = 32'hf802c01c; // Transmit descriptor queue pointer
   localparam logic [31:0] RX_STATUS_ADDR = 32'hf802c020;    // Receive status, write one to clear
   localparam logic [31:0] IRQ_STATUS_ADDR = 32'hf802c024;   // Interrupt status, clear on read
   localparam logic [31:0] IRQ_ENABLE_ADDR = 32'hf802c028;   // Interrupt enable, write only
   localparam logic [31:0] IRQ_DISABLE_ADDR = 32'hf802c02c;  // Interrupt disable, write only
   localparam logic [31:0] IRQ_MASK_ADDR = 32'hf802c030;     // Interrupt mask, read only

   // Receive status flag positions
   localparam int RX_BUF_UNAVAIL_BIT = 0;  // buffer_unavailable
   localparam int RX_FRAME_RECV_BIT = 1;   // frame_received
   localparam int RX_OVERRUN_BIT = 2;      // receive_overrun
   localparam int RX_STATUS_WIDTH = 3;

   // Interrupt status, enable, disable and mask bit positions
   localparam int IRQ_MGMT_DONE_BIT = 0;      // management_done
   localparam int IRQ_RX_COMPLETE_BIT = 1;    // receive_complete
   localparam int IRQ_RX_OWNED_BIT = 2;       // rx_owned_descriptor
   localparam int IRQ_TX_OWNED_BIT = 3;       // tx_owned_descriptor
   localparam int IRQ_TX_UNDERRUN_BIT = 4;    // transmit_underrun
   localparam int IRQ_RETRY_LIMIT_BIT = 5;    // retry_limit_irq
   localparam int IRQ_TX_ERROR_BIT = 6;       // transmit_error
   localparam int IRQ_TX_COMPLETE_BIT = 7;    // transmit_complete
   localparam int IRQ_RX_OVERRUN_BIT = 10;    // receive_overrun_irq
   localparam int IRQ_BUS_ERROR_BIT = 11;     // bus error response seen by the DMA
   localparam int IRQ_PAUSE_RECV_BIT = 12;    // pause_received_irq
   localparam int IRQ_PAUSE_ZERO_BIT = 13;    // pause_time_zero

   // Implemented interrupt bits; everything else is reserved and reads zero
   localparam logic [31:0] IRQ_VALID_BITS = 32'h00003cff;
   localparam logic [31:0] IRQ_STATUS_RESET = 32'h00000000; // No events pending after reset
   localparam logic [31:0] IRQ_MASK_RESET = 32'h00003cff;   // All sources masked after reset

   // Queue pointer layout: two-word descriptors, 1024 entries in the low-order index
   localparam int DESC_INDEX_LSB = 3;
   localparam int DESC_INDEX_MSB = 12;
   localparam int DESC_INDEX_WIDTH = 10;
   localparam logic [31:0] QUEUE_PTR_WORD_MASK = 32'hfffffffc; // Bits 1:0 read as zero
   localparam logic [31:0] QUEUE_PTR_RESET = 32'h00000000;
   localparam logic [31:0] READ_DATA_IDLE = 32'h00000000;     // Read data outside the answer cycle
endpackage : mac_dma_status_pkg

/* File: src/irq_bank_if.sv */
// Carrier between the register front end and the interrupt status bank
`timescale 1ns/1ps
interface irq_bank_if;
   logic [31:0] events;      // Hardware event pulses, one bit per interrupt source
   logic readClear;          // Software read of the interrupt status register
   logic enableWrite;        // Write strobe for the interrupt enable register
   logic disableWrite;       // Write strobe for the interrupt disable register
   logic [31:0] wrData;      // Write data for enable or disable
   logic [31:0] status;      // Registered interrupt status
   logic [31:0] mask;        // Registered interrupt mask, one means masked
   logic irq;                // Registered interrupt request

   modport ctrl (output events, output readClear, output enableWrite, output disableWrite,
                 output wrData, input status, input mask, input irq);
   modport bank (input events, input readClear, input enableWrite, input disableWrite,
                 input wrData, output status, output mask, output irq);
endinterface : irq_bank_if

/* File: src/irq_status_bank.sv */
// Interrupt status, mask and request logic of the MAC DMA status block
`timescale 1ns/1ps
module irq_status_bank (
   input wire logic clk,
   input wire logic rst,
   irq_bank_if.bank bus
);
   // Whole state of the bank in one packed word
   typedef struct packed {
      logic [31:0] status;  // Sticky event flags
      logic [31:0] mask;    // One means the source is masked
      logic irq;            // Interrupt request
   } bank_state_t;

   bank_state_t state_reg;
   bank_state_t state_next;

   // Next state: clear on read, then events set; the set wins so no event is lost
   always_comb begin
      state_next = state_reg;
      if (bus.readClear) begin
         state_next.status = '0;
      end
      state_next.status = (state_next.status | bus.events) & mac_dma_status_pkg::IRQ_VALID_BITS;
      // Ones in the enable write unmask, zeros leave the source alone
      if (bus.enableWrite) begin
         state_next.mask = state_next.mask & ~bus.wrData;
      end
      // Ones in the disable write mask, zeros leave the source alone
      if (bus.disableWrite) begin
         state_next.mask = state_next.mask | bus.wrData;
      end
      state_next.mask = state_next.mask & mac_dma_status_pkg::IRQ_VALID_BITS;
      // Request follows the new flags so it drops in the same edge that a read clears them
      state_next.irq = |(state_next.status & ~state_next.mask);
   end

   // State register with synchronous reset
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg.status <= mac_dma_status_pkg::IRQ_STATUS_RESET;
         state_reg.mask <= mac_dma_status_pkg::IRQ_MASK_RESET;
         state_reg.irq <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus.status = state_reg.status;
   assign bus.mask = state_reg.mask;
   assign bus.irq = state_reg.irq;
endmodule : irq_status_bank

/* File: src/mac_dma_status_irq.sv */
// MAC DMA front end: transmit queue pointer, receive status and interrupt registers
//
// Summary of operation
// - Queue pointer index advances, wraps on 1024 or flag
// - Pointer write ignored while transmit is active
// - Pointer read gives current frame's first buffer
// - Receive flags at bits 0-2, write one clears
// - Every failed receive fetch sets buffer unavailable
// - After failed fetch, refetch at each frame start
// - Stored complete frame sets frame received flag
// - Lost frame sets overrun and reclaims its buffer
// - Reading interrupt status clears all its flags
// - Finished PHY management operation sets bit 0
// - Frame written to memory sets bit 1
// - Owned receive/transmit descriptor sets bit 2/3
// - Late data, mid-frame used, pointer write: bit 4
// - Buffers exhausted mid-frame set bit 6
// - Finished frame transmission sets bit 7
// - Receive overrun condition sets bit 10
// - Bus error response sets bit 11
// - Valid pause frame sets bit 12
// - Pause time reaching zero sets bit 13
// - Enable write unmasks sources at status positions
// - Disable write masks sources at status positions
// - Mask register shows which sources are masked
// - Transmit active input blocks pointer writes
`timescale 1ns/1ps
module mac_dma_status_irq (
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   // Transmit engine
   input wire logic transmitActive,
   input wire logic txFrameStart,
   input wire logic txBufferConsumed,
   input wire logic txDescWrap,
   input wire logic txDescOwnedByCpu,
   input wire logic txDataLate,
   input wire logic txUsedMidFrame,
   input wire logic txBuffersExhausted,
   input wire logic txRetryLimit,
   input wire logic txFrameDone,
   output logic [31:0] txDescAddr,
   // Receive engine
   input wire logic rxFrameStart,
   input wire logic rxDescFetchOk,
   input wire logic rxDescOwnedByCpu,
   input wire logic rxFrameStored,
   input wire logic rxOverrun,
   output logic rxRefetchPending,
   output logic rxFetchRequest,
   output logic rxBufferReclaim,
   // Other event sources
   input wire logic mgmtDone,
   input wire logic busError,
   input wire logic pauseFrameValid,
   input wire logic pauseTimeZero,
   // Interrupt request
   output logic irq
);
   // Receive descriptor fetch state, Gray coded
   typedef enum logic [0:0] {
      RX_FETCH_NORMAL = 1'b0,  // Last fetch found a descriptor we own
      RX_FETCH_RETRY = 1'b1    // Waiting for the next frame to fetch again
   } rx_fetch_t;

   // Whole state of the front end in one packed word
   typedef struct packed {
      logic [31:0] txStart;            // Written start of the descriptor list
      logic [31:0] txCur;              // Descriptor currently in use by the DMA
      logic [31:0] txFirst;            // First buffer of the frame in flight
      logic [2:0] rxStatus;            // Receive status flags
      rx_fetch_t rxFetch;              // Receive fetch retry state
      logic fetchReq;                  // Refetch request pulse
      logic reclaim;                   // Buffer reclaim pulse
      logic [31:0] rdData;             // Read answer, valid one cycle
   } front_state_t;

   front_state_t state_reg;
   front_state_t state_next;

   irq_bank_if bankBus ();

   // Width of the descriptor index field, declared before the index signal that uses it
   localparam int DESC_WIDTH_LOCAL = mac_dma_status_pkg::DESC_INDEX_WIDTH;

   // Address decode of the register port
   logic hitTxPtr;
   logic hitRxStatus;
   logic hitIrqStatus;
   logic hitIrqEnable;
   logic hitIrqDisable;
   logic hitIrqMask;
   logic txPtrWriteOk;             // A pointer write that is actually taken
   logic [DESC_WIDTH_LOCAL-1:0] nextIndex;
   logic [31:0] irqEvents;

   assign hitTxPtr = (regAddr == mac_dma_status_pkg::TX_QUEUE_PTR_ADDR);
   assign hitRxStatus = (regAddr == mac_dma_status_pkg::RX_STATUS_ADDR);
   assign hitIrqStatus = (regAddr == mac_dma_status_pkg::IRQ_STATUS_ADDR);
   assign hitIrqEnable = (regAddr == mac_dma_status_pkg::IRQ_ENABLE_ADDR);
   assign hitIrqDisable = (regAddr == mac_dma_status_pkg::IRQ_DISABLE_ADDR);
   assign hitIrqMask = (regAddr == mac_dma_status_pkg::IRQ_MASK_ADDR);

   // Transmit engine owns the pointer while a frame is going out
   assign txPtrWriteOk = regWrite && hitTxPtr && !transmitActive;

   // Index field counts modulo 1024, so it returns to the written value by itself
   assign nextIndex = state_reg.txCur[mac_dma_status_pkg::DESC_INDEX_MSB:mac_dma_status_pkg::DESC_INDEX_LSB]
                      + 10'h001;

   // Gather event pulses into interrupt status positions
   always_comb begin
      irqEvents = 32'h00000000;
      irqEvents[mac_dma_status_pkg::IRQ_MGMT_DONE_BIT] = mgmtDone;
      irqEvents[mac_dma_status_pkg::IRQ_RX_COMPLETE_BIT] = rxFrameStored;
      irqEvents[mac_dma_status_pkg::IRQ_RX_OWNED_BIT] = rxDescOwnedByCpu;
      irqEvents[mac_dma_status_pkg::IRQ_TX_OWNED_BIT] = txDescOwnedByCpu;
      // Underrun also covers a pointer rewrite, since it abandons the queue in flight
      irqEvents[mac_dma_status_pkg::IRQ_TX_UNDERRUN_BIT] = txDataLate | txUsedMidFrame | txPtrWriteOk;
      irqEvents[mac_dma_status_pkg::IRQ_RETRY_LIMIT_BIT] = txRetryLimit;
      irqEvents[mac_dma_status_pkg::IRQ_TX_ERROR_BIT] = txBuffersExhausted;
      irqEvents[mac_dma_status_pkg::IRQ_TX_COMPLETE_BIT] = txFrameDone;
      irqEvents[mac_dma_status_pkg::IRQ_RX_OVERRUN_BIT] = rxOverrun;
      irqEvents[mac_dma_status_pkg::IRQ_BUS_ERROR_BIT] = busError;
      irqEvents[mac_dma_status_pkg::IRQ_PAUSE_RECV_BIT] = pauseFrameValid;
      irqEvents[mac_dma_status_pkg::IRQ_PAUSE_ZERO_BIT] = pauseTimeZero;
   end

   // Drive the interrupt bank through its carrier
   assign bankBus.events = irqEvents;
   assign bankBus.readClear = regRead && hitIrqStatus;
   assign bankBus.enableWrite = regWrite && hitIrqEnable;
   assign bankBus.disableWrite = regWrite && hitIrqDisable;
   assign bankBus.wrData = regWrData;

   irq_status_bank bank (
      .clk(clk),
      .rst(rst),
      .bus(bankBus)
   );

   // Next state of the front end
   always_comb begin
      state_next = state_reg;
      state_next.fetchReq = 1'b0;
      state_next.reclaim = 1'b0;
      state_next.rdData = mac_dma_status_pkg::READ_DATA_IDLE;

      // Transmit pointer: software write restarts the list, otherwise the DMA walks it
      if (txPtrWriteOk) begin
         // Bit 2 is kept as written; software keeps it zero to avoid a burst over a 1K line
         state_next.txStart = regWrData & mac_dma_status_pkg::QUEUE_PTR_WORD_MASK;
         state_next.txCur = regWrData & mac_dma_status_pkg::QUEUE_PTR_WORD_MASK;
         state_next.txFirst = regWrData & mac_dma_status_pkg::QUEUE_PTR_WORD_MASK;
      end else begin
         // Remember where the frame now starting began
         if (txFrameStart) begin
            state_next.txFirst = state_reg.txCur;
         end
         if (txBufferConsumed) begin
            if (txDescWrap) begin
               state_next.txCur = state_reg.txStart;
            end else begin
               state_next.txCur[mac_dma_status_pkg::DESC_INDEX_MSB:mac_dma_status_pkg::DESC_INDEX_LSB] =
                  nextIndex;
            end
         end
      end

      // Receive status: write one clears, hardware set wins in the same cycle
      if (regWrite && hitRxStatus) begin
         state_next.rxStatus = state_reg.rxStatus & ~regWrData[2:0];
      end
      if (rxDescOwnedByCpu) begin
         state_next.rxStatus[mac_dma_status_pkg::RX_BUF_UNAVAIL_BIT] = 1'b1;
      end
      if (rxFrameStored) begin
         state_next.rxStatus[mac_dma_status_pkg::RX_FRAME_RECV_BIT] = 1'b1;
      end
      if (rxOverrun) begin
         state_next.rxStatus[mac_dma_status_pkg::RX_OVERRUN_BIT] = 1'b1;
         state_next.reclaim = 1'b1;
      end

      // Receive fetch retry: a failed fetch is retried at each new frame
      case (state_reg.rxFetch)
         RX_FETCH_NORMAL: begin
            if (rxDescOwnedByCpu) begin
               state_next.rxFetch = RX_FETCH_RETRY;
            end
         end
         RX_FETCH_RETRY: begin
            if (rxDescFetchOk) begin
               state_next.rxFetch = RX_FETCH_NORMAL;
            end else if (rxFrameStart) begin
               state_next.fetchReq = 1'b1;
            end
         end
         default: begin
            state_next.rxFetch = RX_FETCH_NORMAL;
         end
      endcase

      // Read answer, registered so it stands only in the cycle after the strobe
      if (regRead) begin
         if (hitTxPtr) begin
            state_next.rdData = state_reg.txFirst;
         end else if (hitRxStatus) begin
            state_next.rdData = {29'h00000000, state_reg.rxStatus};
         end else if (hitIrqStatus) begin
            state_next.rdData = bankBus.status;
         end else if (hitIrqMask) begin
            state_next.rdData = bankBus.mask;
         end else begin
            // Write-only and unmapped addresses read as zero
            state_next.rdData = mac_dma_status_pkg::READ_DATA_IDLE;
         end
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg.txStart <= mac_dma_status_pkg::QUEUE_PTR_RESET;
         state_reg.txCur <= mac_dma_status_pkg::QUEUE_PTR_RESET;
         state_reg.txFirst <= mac_dma_status_pkg::QUEUE_PTR_RESET;
         state_reg.rxStatus <= 3'h0;
         state_reg.rxFetch <= RX_FETCH_NORMAL;
         state_reg.fetchReq <= 1'b0;
         state_reg.reclaim <= 1'b0;
         state_reg.rdData <= mac_dma_status_pkg::READ_DATA_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign regRdData = state_reg.rdData;
   assign txDescAddr = state_reg.txCur;
   assign rxRefetchPending = (state_reg.rxFetch == RX_FETCH_RETRY);
   assign rxFetchRequest = state_reg.fetchReq;
   assign rxBufferReclaim = state_reg.reclaim;
   assign irq = bankBus.irq;
endmodule : mac_dma_status_irq

/* File: verif/mac_dma_status_chk.sv */
// Port-level assertions for the MAC DMA status and interrupt block
`timescale 1ns/1ps
module mac_dma_status_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdData,
   input wire logic transmitActive,
   input wire logic txBufferConsumed,
   input wire logic txDescWrap,
   input wire logic [31:0] txDescAddr,
   input wire logic rxFrameStart,
   input wire logic rxDescFetchOk,
   input wire logic rxDescOwnedByCpu,
   input wire logic rxOverrun,
   input wire logic rxRefetchPending,
   input wire logic rxFetchRequest,
   input wire logic rxBufferReclaim
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic ptrWr; // Software write aimed at the queue pointer
   logic irqRead; // Read of the status or mask register
   assign ptrWr = regWrite && regAddr == mac_dma_status_pkg::TX_QUEUE_PTR_ADDR;
   assign irqRead = regRead && (regAddr == mac_dma_status_pkg::IRQ_STATUS_ADDR ||
                                regAddr == mac_dma_status_pkg::IRQ_MASK_ADDR);
   // A write while idle loads the pointer, low two bits dropped
   property p_ptr_load;
      ptrWr && !transmitActive && !txBufferConsumed |=>
         txDescAddr == ($past(regWrData) & mac_dma_status_pkg::QUEUE_PTR_WORD_MASK);
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("queue pointer write not loaded");
   // A write during transmit must leave the pointer untouched
   property p_ptr_blocked;
      ptrWr && transmitActive && !txBufferConsumed |=> $stable(txDescAddr);
   endproperty
   a_ptr_blocked: assert property (p_ptr_blocked) else $error("pointer changed while transmitting");
   // Each consumed buffer moves the index by one, modulo 1024
   property p_advance;
      txBufferConsumed && !txDescWrap && !ptrWr |=> txDescAddr[12:3] == $past(txDescAddr[12:3]) + 10'h1
         && txDescAddr[31:13] == $past(txDescAddr[31:13]);
   endproperty
   a_advance: assert property (p_advance) else $error("descriptor index did not advance by one");
   // Reserved interrupt bits always read zero
   property p_reserved;
      irqRead |=> (regRdData & ~mac_dma_status_pkg::IRQ_VALID_BITS) == 32'h00000000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved interrupt bit read high");
   // A failed fetch enters the retry state
   property p_retry_enter;
      rxDescOwnedByCpu && !rxDescFetchOk |=> rxRefetchPending;
   endproperty
   a_retry_enter: assert property (p_retry_enter) else $error("failed fetch did not start retry");
   // A good fetch leaves the retry state
   property p_retry_leave;
      rxDescFetchOk && !rxDescOwnedByCpu |=> !rxRefetchPending;
   endproperty
   a_retry_leave: assert property (p_retry_leave) else $error("retry state kept after good fetch");
   // Each new frame while retrying asks for the descriptor again
   property p_refetch;
      rxRefetchPending && rxFrameStart && !rxDescFetchOk |=> rxFetchRequest ##1 !rxFetchRequest[*1];
   endproperty
   a_refetch: assert property (p_refetch) else $error("no single refetch after frame start");
   // A lost frame hands its buffer back one cycle later
   property p_reclaim;
      rxOverrun |=> rxBufferReclaim;
   endproperty
   a_reclaim: assert property (p_reclaim) else $error("overrun did not reclaim the buffer");
   c_refetch: cover property (rxFetchRequest);
   c_wrap: cover property (txBufferConsumed && txDescWrap);
   c_blocked: cover property (ptrWr && transmitActive);
endmodule : mac_dma_status_chk
bind mac_dma_status_irq mac_dma_status_chk mac_dma_status_chk_inst (.clk(clk), .rst(rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
   .transmitActive(transmitActive), .txBufferConsumed(txBufferConsumed), .txDescWrap(txDescWrap),
   .txDescAddr(txDescAddr), .rxFrameStart(rxFrameStart), .rxDescFetchOk(rxDescFetchOk),
   .rxDescOwnedByCpu(rxDescOwnedByCpu), .rxOverrun(rxOverrun), .rxRefetchPending(rxRefetchPending),
   .rxFetchRequest(rxFetchRequest), .rxBufferReclaim(rxBufferReclaim));

/* File: verif/testbench.sv */
// Self-checking bench for the MAC DMA status and interrupt block
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] TQ = mac_dma_status_pkg::TX_QUEUE_PTR_ADDR; // Short register aliases
   localparam logic [31:0] RS = mac_dma_status_pkg::RX_STATUS_ADDR;
   localparam logic [31:0] IS = mac_dma_status_pkg::IRQ_STATUS_ADDR;
   localparam logic [31:0] IM = mac_dma_status_pkg::IRQ_MASK_ADDR;
   logic clk, rst, regWrite, regRead, transmitActive, irq;
   logic [31:0] regAddr, regWrData, regRdData, txDescAddr;
   logic rxRefetchPending, rxFetchRequest, rxBufferReclaim;
   logic [17:0] ev; // Event pulses; bits 0-7 and 10-13 line up with interrupt status bits
   int mismatches, samples_checked;
   mac_dma_status_irq mac_dma_status_irq_inst (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .transmitActive(transmitActive),
      .txFrameStart(ev[14]), .txBufferConsumed(ev[15]), .txDescWrap(ev[16]), .txDescOwnedByCpu(ev[3]),
      .txDataLate(ev[4]), .txUsedMidFrame(ev[8]), .txBuffersExhausted(ev[6]), .txRetryLimit(ev[5]),
      .txFrameDone(ev[7]), .txDescAddr(txDescAddr), .rxFrameStart(ev[9]), .rxDescFetchOk(ev[17]),
      .rxDescOwnedByCpu(ev[2]), .rxFrameStored(ev[1]), .rxOverrun(ev[10]), .rxRefetchPending(rxRefetchPending),
      .rxFetchRequest(rxFetchRequest), .rxBufferReclaim(rxBufferReclaim), .mgmtDone(ev[0]),
      .busError(ev[11]), .pauseFrameValid(ev[12]), .pauseTimeZero(ev[13]), .irq(irq));
   // 25 ns clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Compare one value, count it, report a difference
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // One-cycle register write
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   // One-cycle read; data stands only in the following cycle
   task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      chk(name, regRdData, exp);
   endtask : rd
   // One-cycle event pulse on the selected sources
   task automatic pulse(input logic [17:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= '0;
   endtask : pulse
   // Counts, verdict and end of run
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      stop_test();
   end
   // Main sequence
   initial begin
      int b;
      rst = 1'b1;
      regAddr = '0;
      regWrData = '0;
      regWrite = 1'b0;
      regRead = 1'b0;
      transmitActive = 1'b0;
      ev = '0;
      mismatches = 0;
      samples_checked = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd("mask", IM, 32'h00003cff);
      rd("status", IS, 32'h00000000);
      // Every source sets its own bit, and a read clears it
      for (int i = 0; i < 14; i++) begin
         if (i == 9)
            continue;
         b = (i == 8) ? 4 : i;
         pulse(18'h1 << i);
         rd("status", IS, 32'h1 << b);
         rd("status", IS, 32'h00000000);
      end
      // Retry after a failed fetch, at each frame start
      for (int j = 0; j < 2; j++) begin
         pulse(18'h00200);
         #1;
         chk("fetch", {31'h0, rxFetchRequest}, 32'h1);
      end
      pulse(18'h20000);
      pulse(18'h00200);
      #1;
      chk("fetch", {31'h0, rxFetchRequest | rxRefetchPending}, 32'h0);
      pulse(18'h00400);
      #1;
      chk("reclaim", {31'h0, rxBufferReclaim}, 32'h1);
      rd("status", IS, 32'h00000400);
      // Receive flags clear by writing one, never set by a write
      rd("rx", RS, 32'h00000007);
      wr(RS, 32'h00000002);
      rd("rx", RS, 32'h00000005);
      wr(RS, 32'h00000005);
      wr(RS, 32'h00000007);
      rd("rx", RS, 32'h00000000);
      pulse(18'h00004);
      wr(RS, 32'h00000001);
      pulse(18'h00004);
      rd("rx", RS, 32'h00000001);
      rd("status", IS, 32'h00000004);
      // Mask control through enable and disable
      wr(mac_dma_status_pkg::IRQ_ENABLE_ADDR, 32'hffffffff);
      rd("mask", IM, 32'h00000000);
      wr(mac_dma_status_pkg::IRQ_DISABLE_ADDR, 32'h00000003);
      wr(mac_dma_status_pkg::IRQ_DISABLE_ADDR, 32'h00000000);
      wr(IM, 32'h00000000);
      wr(32'hf802c040, 32'hffffffff);
      rd("mask", IM, 32'h00000003);
      rd("enable", mac_dma_status_pkg::IRQ_ENABLE_ADDR, 32'h00000000);
      pulse(18'h00001);
      #1;
      chk("irq", {31'h0, irq}, 32'h0);
      pulse(18'h00080);
      #1;
      chk("irq", {31'h0, irq}, 32'h1);
      rd("status", IS, 32'h00000081);
      chk("irq", {31'h0, irq}, 32'h0);
      // Queue pointer load, lock-out, advance and wrap
      wr(TQ, 32'h20001007);
      rd("ptr", TQ, 32'h20001004);
      rd("status", IS, 32'h00000010);
      @(posedge clk) transmitActive <= 1'b1;
      wr(TQ, 32'h30000000);
      rd("ptr", TQ, 32'h20001004);
      rd("status", IS, 32'h00000000);
      pulse(18'h08000);
      #1;
      chk("desc", txDescAddr, 32'h2000100c);
      rd("ptr", TQ, 32'h20001004);
      pulse(18'h04000);
      rd("ptr", TQ, 32'h2000100c);
      pulse(18'h18000);
      #1;
      chk("desc", txDescAddr, 32'h20001004);
      @(posedge clk) transmitActive <= 1'b0;
      wr(TQ, 32'h20000000);
      @(posedge clk) ev[15] <= 1'b1;
      repeat (1023) @(posedge clk);
      #1;
      chk("desc", txDescAddr, 32'h20001ff8);
      @(posedge clk) ev[15] <= 1'b0;
      #1;
      chk("desc", txDescAddr, 32'h20000000);
      stop_test();
   end
endmodule : testbench
